/* File: verilog/flrb_top.sv */
// fault log record builder: working log, freeze and 147-byte readout
//
// Summary of operation
// - bytes 27..46 hold the record of the cycle in which the fault hit
// - bytes 47..146 hold five older records, newest first, oldest last
// - bytes 0..3 hold a fixed preface identifier with a factory code
// - byte 4 holds the fault source code: cause, plus 0x10 for channel 1, 0xFF manual
// - bytes 5..10 hold the 48-bit timestamp at the fault, low byte first
// - bytes 11..14 hold output voltage peaks since reset or peak clear
// - bytes 15..18 hold output current peaks since reset or peak clear
// - bytes 19..20 hold the input voltage peak since reset or peak clear
// - bytes 21..26 hold the last two external and the internal temperature
// - records: voltages, currents, input, spare, status vout, words, mfr status
// - 16-bit fields go out high byte first
// - block read is 147 bytes; count reads zero with no log
// - six newest records kept in working memory, newest first
// - a fault stops log updates and offers the frozen image
`timescale 1ns/10ps
`include "flrb_regs.svh"
module flrb_top
    import flrb_pkg::*;
#(
    // arbitrary identifier value
    parameter logic [31:0] PREFACE_ID = `FLRB_PREFACE_ID
)
(
    // clock and reset
    input logic clock_i,
    input logic nrst_i,
    // telemetry from the monitor
    input logic tel_valid_i,
    input flrb_tel_t tel_i,
    input logic cycle_done_i,
    input logic [47:0] shared_timestamp_counter_i,
    // fault and commands
    input flrb_fault_t fault_i,
    input logic manual_log_store_command_i,
    input logic clear_peaks_i,
    input logic clear_log_i,
    // fault_log_readout_command byte stream
    input logic rd_start_i,
    input logic rd_next_i,
    output logic [7:0] rd_count_o,
    output logic [7:0] rd_data_o,
    output logic rd_last_o,
    output logic log_valid_o
);

    // ==========================================================
    // state
    flrb_state_t state_ff;
    flrb_state_t nxt_state;
    logic frozen;
    logic start_cap;
    logic shift;
    logic tel_take;

    assign frozen = (state_ff == ST_FROZEN);
    assign start_cap = (state_ff == ST_RUN) && (fault_i.req || manual_log_store_command_i);
    assign shift = (state_ff == ST_RUN) && cycle_done_i;
    // the fault record keeps filling until its cycle ends
    assign tel_take = tel_valid_i && !frozen;

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_RUN: begin
                if (start_cap) begin
                    nxt_state = ST_CAPTURE;
                end
            end
            ST_CAPTURE: begin
                if (cycle_done_i) begin
                    nxt_state = ST_FROZEN;
                end
            end
            ST_FROZEN: begin
                if (clear_log_i) begin
                    nxt_state = ST_RUN;
                end
            end
            default: begin
                nxt_state = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_ff <= ST_RUN;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ==========================================================
    // fault source and timestamp
    // a fault beats a manual store raised in the same cycle
    logic [7:0] src_ff;
    logic [7:0] nxt_src;
    logic [47:0] ts_ff;

    assign nxt_src = fault_i.req ? {3'b000, fault_i.chan, fault_i.cause} : `FLRB_SRC_MANUAL;

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            src_ff <= 8'h00;
            ts_ff <= 48'h0000_0000_0000;
        end else if (start_cap) begin
            src_ff <= nxt_src;
            ts_ff <= shared_timestamp_counter_i;
        end
    end

    // ==========================================================
    // working memory of six records, index 0 newest
    flrb_rec_t rec_mem [0:`FLRB_REC_NUM-1];

    generate
        for (genvar k = 0; k < `FLRB_REC_NUM; k++) begin : g_rec
            if (k == 0) begin : g_live
                always_ff @(posedge clock_i or negedge nrst_i) begin
                    if (!nrst_i) begin
                        rec_mem[k] <= '0;
                    end else if (tel_take) begin
                        rec_mem[k] <= tel_i.rec;
                    end
                end
            end else begin : g_hist
                always_ff @(posedge clock_i or negedge nrst_i) begin
                    if (!nrst_i) begin
                        rec_mem[k] <= '0;
                    end else if (shift) begin
                        rec_mem[k] <= rec_mem[k-1];
                    end
                end
            end
        end
    endgenerate

    // ==========================================================
    // temperatures of the last event
    logic [15:0] temp_ext0_ff;
    logic [15:0] temp_ext1_ff;
    logic [15:0] temp_int_ff;

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            temp_ext0_ff <= 16'h0000;
            temp_ext1_ff <= 16'h0000;
            temp_int_ff <= 16'h0000;
        end else if (tel_take) begin
            temp_ext0_ff <= tel_i.temp_ext0;
            temp_ext1_ff <= tel_i.temp_ext1;
            temp_int_ff <= tel_i.temp_int;
        end
    end

    // ==========================================================
    // peaks: vout0, vout1, iout0, iout1, vin
    logic [15:0] pk_in [0:4];
    logic [15:0] pk [0:4];

    assign pk_in[0] = tel_i.rec.vout0;
    assign pk_in[1] = tel_i.rec.vout1;
    assign pk_in[2] = tel_i.rec.iout0;
    assign pk_in[3] = tel_i.rec.iout1;
    assign pk_in[4] = tel_i.rec.vin;

    generate
        for (genvar p = 0; p < 5; p++) begin : g_peak
            // frozen peaks also ignore a clear, so the image stays whole
            flrb_peak u_peak (
                .clock_i(clock_i),
                .nrst_i(nrst_i),
                .sample_i(tel_take),
                .clear_i(clear_peaks_i),
                .hold_i(frozen),
                .value_i(pk_in[p]),
                .peak_o(pk[p])
            );
        end
    endgenerate

    // ==========================================================
    // header image
    flrb_hdr_t hdr;

    assign hdr.preface = PREFACE_ID;
    assign hdr.src = src_ff;
    generate
        for (genvar b = 0; b < 6; b++) begin : g_ts
            assign hdr.ts_le[47-8*b -: 8] = ts_ff[8*b +: 8];
        end
    endgenerate
    assign hdr.pk_vout0 = pk[0];
    assign hdr.pk_vout1 = pk[1];
    assign hdr.pk_iout0 = pk[2];
    assign hdr.pk_iout1 = pk[3];
    assign hdr.pk_vin = pk[4];
    assign hdr.temp_ext0 = temp_ext0_ff;
    assign hdr.temp_ext1 = temp_ext1_ff;
    assign hdr.temp_int = temp_int_ff;

    // ==========================================================
    // readout walker
    logic [7:0] rd_idx_ff;
    logic [2:0] rd_rec_ff;
    logic [4:0] rd_off_ff;
    logic [7:0] nxt_idx;
    logic [2:0] nxt_rec;
    logic [4:0] nxt_off;
    logic step;
    logic in_recs;
    logic wrap;
    logic [7:0] hdr_byte;
    logic [7:0] rec_byte;
    logic [7:0] nxt_data;

    assign step = rd_next_i && (rd_idx_ff != `FLRB_LAST_BYTE);
    assign in_recs = (rd_idx_ff >= `FLRB_HDR_LEN);
    assign wrap = (rd_off_ff == `FLRB_REC_LAST);

    assign nxt_idx = rd_start_i ? 8'h00 : step ? rd_idx_ff + 8'h01 : rd_idx_ff;
    assign nxt_rec = rd_start_i ? 3'h0 :
                     (step && in_recs && wrap) ? rd_rec_ff + 3'h1 : rd_rec_ff;
    assign nxt_off = rd_start_i ? 5'h00 :
                     (step && in_recs) ? (wrap ? 5'h00 : rd_off_ff + 5'h01) : rd_off_ff;

    // fields are packed high byte first, so a plain byte slice keeps that order
    assign hdr_byte = flrb_byte(hdr, nxt_idx[4:0]);
    assign rec_byte = flrb_byte({rec_mem[nxt_rec], `FLRB_REC_PAD}, nxt_off);
    assign nxt_data = !frozen ? 8'h00 :
                      (nxt_idx < `FLRB_HDR_LEN) ? hdr_byte : rec_byte;

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rd_idx_ff <= 8'h00;
            rd_rec_ff <= 3'h0;
            rd_off_ff <= 5'h00;
            rd_data_o <= 8'h00;
            rd_last_o <= 1'b0;
        end else begin
            rd_idx_ff <= nxt_idx;
            rd_rec_ff <= nxt_rec;
            rd_off_ff <= nxt_off;
            rd_data_o <= nxt_data;
            rd_last_o <= (nxt_idx == `FLRB_LAST_BYTE);
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rd_count_o <= `FLRB_NO_LOG_LEN;
            log_valid_o <= 1'b0;
        end else begin
            rd_count_o <= (nxt_state == ST_FROZEN) ? `FLRB_LOG_LEN : `FLRB_NO_LOG_LEN;
            log_valid_o <= (nxt_state == ST_FROZEN);
        end
    end

    // ==========================================================
    // assertions
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);

    sequence s_fault_taken;
        (state_ff == ST_RUN) && fault_i.req;
    endsequence

    sequence s_manual_taken;
        (state_ff == ST_RUN) && !fault_i.req && manual_log_store_command_i;
    endsequence

    sequence s_read_step(logic [7:0] at);
        frozen && !clear_log_i && !rd_start_i && rd_next_i && (rd_idx_ff == at - 8'h01);
    endsequence

    a_count_state: assert property (
        (rd_count_o == `FLRB_LOG_LEN) == frozen && (rd_count_o == `FLRB_NO_LOG_LEN) == !frozen)
        else $error("block count disagrees with log state");

    a_hist_shift: assert property (
        shift |=> (rec_mem[1] == $past(rec_mem[0])) && (rec_mem[5] == $past(rec_mem[4])))
        else $error("history did not shift on cycle end");

    a_frozen_stable: assert property (
        frozen |=> $stable(rec_mem[0]) && $stable(rec_mem[5]) && $stable(hdr))
        else $error("frozen image changed");

    a_cycle_freeze: assert property (
        s_fault_taken ##1 (!cycle_done_i && tel_valid_i) |=>
        (state_ff == ST_CAPTURE) && (rec_mem[0] == $past(tel_i.rec)))
        else $error("fault record not sampled during capture");

    a_end_freeze: assert property (
        (state_ff == ST_CAPTURE) && cycle_done_i |=> frozen ##1 (rd_count_o == `FLRB_LOG_LEN) || !frozen)
        else $error("capture did not freeze at cycle end");

    a_src_code: assert property (
        s_fault_taken |=> src_ff == {3'b000, $past(fault_i.chan), $past(fault_i.cause)})
        else $error("wrong fault source code");

    a_src_manual: assert property (
        s_manual_taken |=> src_ff == `FLRB_SRC_MANUAL)
        else $error("manual store code missing");

    a_ts_capture: assert property (
        s_fault_taken |=> ts_ff == $past(shared_timestamp_counter_i))
        else $error("timestamp not captured at fault");

    a_preface_byte: assert property (
        frozen && !clear_log_i && rd_start_i |=> rd_data_o == PREFACE_ID[31:24])
        else $error("first byte is not the preface");

    a_peak_byte: assert property (
        s_read_step(`FLRB_B_VOUT_PK0) |=> rd_data_o == pk[0][15:8])
        else $error("channel 0 voltage peak high byte wrong");

    a_fault_rec: assert property (
        s_read_step(`FLRB_B_FAULT_REC) |=> rd_data_o == rec_mem[0].vout0[15:8])
        else $error("fault record not at byte 27");

    a_hist_byte: assert property (
        s_read_step(`FLRB_B_HIST) |=> rd_data_o == rec_mem[1].vout0[15:8])
        else $error("newest history record not at byte 47");

    a_rec_layout: assert property (
        s_read_step(`FLRB_B_REC_STAT) |=> rd_data_o == rec_mem[0].svout0)
        else $error("status byte out of place in record");

endmodule

/* File: verilog/flrb_regs.svh */
// byte layout, reset values and codes of the fault log image
`ifndef FLRB_REGS_SVH
`define FLRB_REGS_SVH

// ==========================================================
// image geometry
`define FLRB_LOG_LEN 8'h93
`define FLRB_NO_LOG_LEN 8'h00
`define FLRB_HDR_LEN 8'h1b
`define FLRB_LAST_BYTE 8'h92
`define FLRB_REC_LAST 5'h13
`define FLRB_REC_NUM 6
`define FLRB_HDR_BITS 216
`define FLRB_REC_PAD 56'h0000_0000_0000_00

// ==========================================================
// byte offsets used to probe the image
`define FLRB_B_VOUT_PK0 8'h0b
`define FLRB_B_FAULT_REC 8'h1b
`define FLRB_B_HIST 8'h2f
`define FLRB_B_REC_STAT 8'h27

// ==========================================================
// codes and reset values
`define FLRB_SRC_MANUAL 8'hff
`define FLRB_SRC_CH_POS 4
`define FLRB_PREFACE_ID 32'h464c_3031
`define FLRB_PEAK_RST 16'h0000

`endif

/* File: verilog/flrb_pkg.sv */
// types shared by the fault log record builder
package flrb_pkg;

    `include "flrb_regs.svh"

    // ==========================================================
    // fault causes, per channel
    typedef enum logic [3:0] {
        C_TON_MAX = 4'h0,
        C_VOUT_OV = 4'h1,
        C_VOUT_UV = 4'h2,
        C_IOUT_OC = 4'h3,
        C_OVER_TEMP = 4'h5,
        C_UNDER_TEMP = 4'h6,
        C_VIN_OV = 4'h7,
        C_INT_TEMP = 4'ha
    } flrb_cause_t;

    typedef enum logic [1:0] {
        ST_RUN = 2'h0,
        ST_CAPTURE = 2'h1,
        ST_FROZEN = 2'h3
    } flrb_state_t;

    // ==========================================================
    // one 20-byte event record, fields in emitted byte order
    typedef struct packed {
        logic [15:0] vout0;
        logic [15:0] vout1;
        logic [15:0] iout0;
        logic [15:0] iout1;
        logic [15:0] vin;
        logic [15:0] spare;
        logic [7:0] svout0;
        logic [7:0] svout1;
        logic [15:0] sword0;
        logic [15:0] sword1;
        logic [7:0] smfr0;
        logic [7:0] smfr1;
    } flrb_rec_t;

    typedef struct packed {
        flrb_rec_t rec;
        logic [15:0] temp_ext0;
        logic [15:0] temp_ext1;
        logic [15:0] temp_int;
    } flrb_tel_t;

    typedef struct packed {
        logic req;
        logic chan;
        flrb_cause_t cause;
    } flrb_fault_t;

    // 27-byte header, fields in emitted byte order
    typedef struct packed {
        logic [31:0] preface;
        logic [7:0] src;
        logic [47:0] ts_le;
        logic [15:0] pk_vout0;
        logic [15:0] pk_vout1;
        logic [15:0] pk_iout0;
        logic [15:0] pk_iout1;
        logic [15:0] pk_vin;
        logic [15:0] temp_ext0;
        logic [15:0] temp_ext1;
        logic [15:0] temp_int;
    } flrb_hdr_t;

    // ==========================================================
    // byte i of a 216-bit image, byte 0 in the top bits
    function automatic logic [7:0] flrb_byte(input logic [215:0] v, input logic [4:0] i);
        logic [7:0] pos;
        pos = 8'hd0 - {i, 3'b000};
        return v[pos +: 8];
    endfunction

endpackage

/* File: verilog/flrb_peak.sv */
// running maximum of one telemetry word
`timescale 1ns/10ps
module flrb_peak
(
    // clock and reset
    input logic clock_i,
    input logic nrst_i,
    // control
    input logic sample_i,
    input logic clear_i,
    input logic hold_i,
    // data
    input logic [15:0] value_i,
    output logic [15:0] peak_o
);

    `include "flrb_regs.svh"

    // ==========================================================
    // peak tracking
    // raw unsigned compare: exact for positive data of one exponent only
    logic [15:0] peak_ff;
    logic [15:0] base;
    logic [15:0] nxt_peak;

    assign base = clear_i ? `FLRB_PEAK_RST : peak_ff;
    assign nxt_peak = hold_i ? peak_ff :
                      (sample_i && (value_i > base)) ? value_i : base;

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            peak_ff <= `FLRB_PEAK_RST;
        end else begin
            peak_ff <= nxt_peak;
        end
    end

    assign peak_o = peak_ff;

endmodule

/* File: verification/flrb_host.sv */
// host side model: runs the byte-stream block read and collects the image
`timescale 1ns/10ps
module flrb_host
(
    // clock
    input wire logic clock_i,
    // readout stream
    input wire logic [7:0] rd_count_i,
    input wire logic [7:0] rd_data_i,
    input wire logic rd_last_i,
    output logic rd_start_o,
    output logic rd_next_o
);
    logic [7:0] img [0:147];
    logic [7:0] count;
    logic last_ok;

    initial begin
        rd_start_o = 1'b0;
        rd_next_o = 1'b0;
    end

    // ==========
    // one read of fixed length, plus one extra next to see the end hold
    task automatic read_log(input bit slow);
        @(negedge clock_i);
        rd_start_o = 1'b1;
        @(negedge clock_i);
        rd_start_o = 1'b0;
        count = rd_count_i;
        last_ok = 1'b1;
        for (int i = 0; i < 148; i++) begin
            img[i] = rd_data_i;
            if ((rd_last_i === 1'b1) != (i >= 146)) last_ok = 1'b0;
            if (slow) begin
                // a slow host pauses; the byte must stand meanwhile
                rd_next_o = 1'b0;
                @(negedge clock_i);
                if (rd_data_i !== img[i]) last_ok = 1'b0;
            end
            rd_next_o = (i < 147);
            @(negedge clock_i);
        end
        rd_next_o = 1'b0;
    endtask
endmodule

/* File: verification/testbench.sv */
// self-checking bench for the fault log record builder
`timescale 1ns/10ps
module testbench
    import flrb_pkg::*;
;
    localparam logic [31:0] PREF = 32'h5a3c_0b17; // arbitrary identifier value
    typedef struct {logic req; logic chan; logic [3:0] cause; logic man; logic [7:0] src;} flrb_row_t;
    logic clock_i, nrst_i, tel_valid, cycle_done, man_store, clr_pk, clr_log, rd_start, rd_next, rd_last, log_valid;
    logic [7:0] rd_count, rd_data;
    logic [47:0] ts;
    logic [15:0] pk;
    flrb_tel_t tel;
    flrb_fault_t fault;
    int num_errors = 0;
    int total_checks = 0;
    int cycles = 0;
    int hist [6] = '{8, 6, 5, 4, 3, 2};
    logic [7:0] exp [0:146];
    logic [3:0] causes [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7, 4'ha};
    flrb_row_t rows [18];

    flrb_top #(.PREFACE_ID(PREF)) dut (.clock_i(clock_i), .nrst_i(nrst_i), .tel_valid_i(tel_valid), .tel_i(tel),
        .cycle_done_i(cycle_done), .shared_timestamp_counter_i(ts), .fault_i(fault),
        .manual_log_store_command_i(man_store), .clear_peaks_i(clr_pk), .clear_log_i(clr_log),
        .rd_start_i(rd_start), .rd_next_i(rd_next), .rd_count_o(rd_count), .rd_data_o(rd_data),
        .rd_last_o(rd_last), .log_valid_o(log_valid));
    flrb_host host (.clock_i(clock_i), .rd_count_i(rd_count), .rd_data_i(rd_data), .rd_last_i(rd_last),
        .rd_start_o(rd_start), .rd_next_o(rd_next));

    initial begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end

    // ==========
    // stimulus values: sample k, 16-bit slot s; the spare slot stays zero
    function automatic logic [15:0] sl(input int k, input int s);
        return (s == 5) ? 16'h0000 : {4'(k == 9 ? 15 : 9 - k), 4'(s), 8'(k)};
    endfunction
    function automatic flrb_tel_t mk(input int k);
        flrb_tel_t t;
        for (int s = 0; s < 13; s++) t[207 - 16 * s -: 16] = sl(k, s);
        return t;
    endfunction
    function automatic logic [7:0] rb(input int k, input int b);
        logic [15:0] w;
        w = sl(k, b / 2);
        return b[0] ? w[7:0] : w[15:8];
    endfunction

    // ==========
    // drivers and checks
    task automatic chk(input logic [7:0] got, input logic [7:0] want);
        total_checks++;
        if (got !== want) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask
    task automatic idle();
        @(negedge clock_i);
        tel_valid = 1'b0;
        cycle_done = 1'b0;
        fault = '0;
        man_store = 1'b0;
        clr_pk = 1'b0;
        clr_log = 1'b0;
    endtask
    task automatic cyc(input int k);
        tel = mk(k);
        tel_valid = 1'b1;
        idle();
        cycle_done = 1'b1;
        idle();
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // the whole run needs about 3300 cycles
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 9000) begin
            num_errors++;
            test_done();
        end
    end

    initial begin
        nrst_i = 1'b0;
        tel = '0;
        ts = '0;
        fault = '0;
        {tel_valid, cycle_done, man_store, clr_pk, clr_log} = 5'h00;
        for (int i = 0; i < 16; i++) rows[i] = '{1'b1, i[3], causes[i % 8], 1'b0, {3'b000, i[3], causes[i % 8]}};
        rows[16] = '{1'b0, 1'b0, 4'h0, 1'b1, 8'hff};
        // fault beats a manual store in the same cycle
        rows[17] = '{1'b1, 1'b1, 4'h7, 1'b1, 8'h17};
        repeat (8) @(negedge clock_i);
        nrst_i = 1'b1;
        idle();
        host.read_log(1'b0);
        chk(host.count, 8'h00);
        chk(host.img[0], 8'h00);
        $display("test no_log done");

        // ==========
        // every fault source, one log each
        for (int i = 0; i < 18; i++) begin
            fault = '{rows[i].req, rows[i].chan, flrb_cause_t'(rows[i].cause)};
            man_store = rows[i].man;
            ts = 48'(i);
            idle();
            cyc(20 + i);
            idle();
            chk({7'h00, log_valid}, 8'h01);
            host.read_log(1'b0);
            chk(host.count, 8'h93);
            chk(host.img[4], rows[i].src);
            chk(host.img[5], 8'(i));
            chk(host.img[27], rb(20 + i, 0));
            chk({7'h00, host.last_ok}, 8'h01);
            clr_log = 1'b1;
            idle();
            idle();
            chk(rd_count, 8'h00);
        end
        $display("test sources done");

        // ==========
        // reset while a log is frozen
        fault = '{1'b1, 1'b0, C_VOUT_OV};
        idle();
        cyc(30);
        idle();
        nrst_i = 1'b0;
        @(negedge clock_i);
        chk(rd_count, 8'h00);
        chk({6'h00, rd_last, log_valid}, 8'h00);
        nrst_i = 1'b1;
        idle();
        $display("test reset done");

        // ==========
        // full image: peak clear, late samples, ignored second fault, frozen inputs
        for (int c = 0; c < 7; c++) begin
            clr_pk = (c == 4);
            cyc(c);
        end
        ts = 48'h0123_4567_89ab;
        fault = '{1'b1, 1'b1, C_IOUT_OC};
        idle();
        ts = 48'hffff_0000_ffff;
        tel = mk(7);
        tel_valid = 1'b1;
        fault = '{1'b1, 1'b0, C_VOUT_OV};
        idle();
        cyc(8);
        idle();
        chk({7'h00, log_valid}, 8'h01);
        tel = mk(9);
        {tel_valid, clr_pk, cycle_done} = 3'b111;
        idle();
        host.read_log(1'b1);
        for (int i = 0; i < 4; i++) exp[i] = PREF[31 - 8 * i -: 8];
        exp[4] = 8'h13;
        for (int i = 0; i < 6; i++) exp[5 + i] = 8'(48'h0123_4567_89ab >> (8 * i));
        for (int p = 0; p < 8; p++) begin
            pk = (p < 5) ? 16'h0000 : sl(8, p + 5);
            for (int k = 4; k < 9 && p < 5; k++) if (sl(k, p) > pk) pk = sl(k, p);
            exp[11 + 2 * p] = pk[15:8];
            exp[12 + 2 * p] = pk[7:0];
        end
        for (int b = 0; b < 120; b++) exp[27 + b] = rb(hist[b / 20], b % 20);
        for (int i = 0; i < 147; i++) chk(host.img[i], exp[i]);
        chk(host.img[147], exp[146]);
        chk(host.count, 8'h93);
        chk({7'h00, host.last_ok}, 8'h01);
        $display("test full_image done");
        test_done();
    end
endmodule
